// >>> core/pfs_pin_function_bank.sv
`timescale 1ns/1ns
// Function
// RL1: per-pin choice of plain or special function
// RL2: software enables pin clocks and reset first
// RL3: pin 0 field bits 2..0, reset 000
// RL4: pin 0 code 001 drives good-frame indicator
// RL5: pin 0 code 010 follows transmit state
// RL6: software never writes codes 011..111
// RL7: indicator pulses on each good-FCS frame
// RL8: pulse length from configured blink time
// RL9: irq enable, status, sense, mode, debounce, raw
// RL10: pin 8 reset 000 is irq output
// RL11: pin 7 needs 001 for plain pin
// RL12: fields three bits, bits 31..27 zero
module pfs_pin_function_bank
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // transceiver status
   input wire logic txActive, // transmitter in its transmit state
   input wire logic rxGoodFrame, // one-cycle pulse per good-FCS frame
   input wire logic devIrq, // device interrupt request level
   // pins
   input wire logic [NUM_PINS-1:0] pinIn,
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe,
   // test input seen on pin 7 in its reset function
   output logic syncIn,
   // interrupt
   output logic irqOut
);
   // ****************************************************
   // registers
   // ****************************************************
   logic [FUNC_BITS-1:0] funcSel_reg; // pin function fields
   logic [PULL_W-1:0] pull_reg; // drive strength
   logic [NUM_PINS-1:0] dir_reg; // 1 = input
   logic [NUM_PINS-1:0] out_reg; // output values
   logic [NUM_PINS-1:0] irqEn_reg;
   logic [NUM_PINS-1:0] irqSts_reg; // latched pin interrupts
   logic [NUM_PINS-1:0] sense_reg; // 1 = active high / rising
   logic [NUM_PINS-1:0] mode_reg; // 1 = edge
   logic [NUM_PINS-1:0] both_reg; // 1 = both edges
   logic [NUM_PINS-1:0] deb_reg; // debounce enable
   logic [2:0] clkCtrl_reg; // clock enables and reset release
   logic [BLINK_W-1:0] blink_reg; // blink time
   logic [EVT_W-1:0] evtSts_reg; // sticky events
   logic [EVT_W-1:0] evtMask_reg;
   logic [NUM_PINS-1:0] syncLvl; // synchronised pins
   logic [NUM_PINS-1:0] debLvl_reg; // debounced level
   logic [NUM_PINS-1:0] prevLvl_reg; // level one cycle ago
   logic [NUM_PINS-1:0] usedLvl; // level used for interrupt detection
   logic [NUM_PINS-1:0] pinHit; // interrupt condition per pin
   logic [31:0] blinkCnt_reg; // blink step divider
   logic [31:0] debCnt_reg; // debounce sample divider
   logic blinkTick;
   logic debTick;
   logic ledActive;
   logic pinLogicOn;

   // pin logic runs only with clocks on and its reset released
   // until then pin status stays clear and plain pins stay released, so a
   // half-configured bank never fights the board
   assign pinLogicOn = clkCtrl_reg[CLK_EN_BIT] & clkCtrl_reg[DCLK_EN_BIT]
      & clkCtrl_reg[DRST_BIT]; // RL2

   // ****************************************************
   // pin input synchronisers
   // ****************************************************
   // each pin comes straight from the board, so each passes its own chain;
   // the raw state view reads these levels, never the pad itself
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : gSync
         pfs_pin_sync uSync (
            .clk_sys(clk_sys),
            .reset(reset),
            .pinIn(pinIn[gi]),
            .pinLevel(syncLvl[gi])
         );
      end
   endgenerate

   // ****************************************************
   // rate dividers
   // ****************************************************
   // blink step and debounce sample enables
   // both dividers run free from reset, so a pulse starts at any phase of
   // its first step; that step may come out shorter than the rest
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         blinkCnt_reg <= ZERO32;
         debCnt_reg <= ZERO32;
      end else begin
         blinkCnt_reg <= blinkTick ? ZERO32 : blinkCnt_reg + 32'h1;
         debCnt_reg <= debTick ? ZERO32 : debCnt_reg + 32'h1;
      end
   end
   // one-cycle enables; nothing in the block runs on a slower clock
   assign blinkTick = (blinkCnt_reg == 32'(BLINK_UNIT_CYC - 1));
   assign debTick = (debCnt_reg == 32'(DEB_UNIT_CYC - 1));

   // ****************************************************
   // good-frame indicator pulse
   // ****************************************************
   // a zero blink time still gives a one-step pulse, so a good frame never
   // goes by without a mark on the pin
   pfs_pulse_timer uLed (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(blinkTick),
      .trigger(rxGoodFrame), // RL7
      .length(blink_reg), // RL8
      .active(ledActive)
   );

   // ****************************************************
   // register writes
   // ****************************************************
   // configuration registers
   // direction resets to input so no plain pin drives the board before setup; pin 8 drives its interrupt request from reset
   // the reserved top bits of the function word are dropped on write;
   // codes 011..111 are stored as written and pin 0 treats them as plain
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         funcSel_reg <= FUNC_RESET[FUNC_BITS-1:0]; // RL3 RL10
         pull_reg <= '1;
         dir_reg <= '1;
         out_reg <= '0;
         irqEn_reg <= '0;
         sense_reg <= '0;
         mode_reg <= '0;
         both_reg <= '0;
         deb_reg <= '0;
         clkCtrl_reg <= '0;
         blink_reg <= BLINK_RESET;
         evtMask_reg <= '0;
      end else if (regWrite) begin
         unique case (regAddr)
            OFS_FUNC_SEL: funcSel_reg <= regWrData[FUNC_BITS-1:0]; // RL1 RL12
            OFS_PULL: pull_reg <= regWrData[PULL_W-1:0];
            OFS_DIR: dir_reg <= regWrData[NUM_PINS-1:0];
            OFS_OUT: out_reg <= regWrData[NUM_PINS-1:0];
            OFS_IRQ_EN: irqEn_reg <= regWrData[NUM_PINS-1:0];
            OFS_IRQ_SENSE: sense_reg <= regWrData[NUM_PINS-1:0];
            OFS_IRQ_MODE: mode_reg <= regWrData[NUM_PINS-1:0];
            OFS_IRQ_BOTH: both_reg <= regWrData[NUM_PINS-1:0];
            OFS_DEBOUNCE: deb_reg <= regWrData[NUM_PINS-1:0];
            OFS_CLK_CTRL: clkCtrl_reg <= regWrData[2:0];
            OFS_BLINK: blink_reg <= regWrData[BLINK_W-1:0];
            OFS_EVT_MASK: evtMask_reg <= regWrData[EVT_W-1:0];
            // read-only and unmapped addresses ignore writes
            default: ;
         endcase
      end
   end

   // ****************************************************
   // pin interrupt detection
   // ****************************************************
   // debounce samples once per 1 us sample period, so a short glitch reaches the latch only if a sample lands on it
   // the edge memory follows the level in use, so turning debounce on may
   // show one false edge; software should clear the latch after it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         debLvl_reg <= '0;
         prevLvl_reg <= '0;
      end else begin
         if (debTick) begin
            debLvl_reg <= syncLvl;
         end
         prevLvl_reg <= usedLvl;
      end
   end

   // per pin level or edge condition
   // level: hit while the level equals the sense bit
   // edge: hit in the cycle of the sensed transition; both: any change
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         usedLvl[i] = deb_reg[i] ? debLvl_reg[i] : syncLvl[i]; // RL9
         if (!mode_reg[i]) begin
            pinHit[i] = (usedLvl[i] == sense_reg[i]);
         end else if (both_reg[i]) begin
            pinHit[i] = (usedLvl[i] != prevLvl_reg[i]);
         end else begin
            pinHit[i] = (usedLvl[i] == sense_reg[i]) && (prevLvl_reg[i] != sense_reg[i]);
         end
      end
   end

   // latched status; a new hit wins over a clear in the same cycle
   // cleared while pin logic is off so stale hits never outlive a restart
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqSts_reg <= '0;
      end else if (!pinLogicOn) begin
         irqSts_reg <= '0;
      end else begin
         irqSts_reg <= (irqSts_reg & ~((regWrite && regAddr == OFS_IRQ_CLR)
            ? regWrData[NUM_PINS-1:0] : '0)) | (pinHit & irqEn_reg); // RL9
      end
   end

   // ****************************************************
   // block events and interrupt output
   // ****************************************************
   // bit 0: any pin interrupt latched, bit 1: good frame received
   // the frame bit lets software poll for frames without watching the pin
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         evtSts_reg <= '0;
      end else begin
         evtSts_reg <= (evtSts_reg & ~((regWrite && regAddr == OFS_EVT_STS)
            ? regWrData[EVT_W-1:0] : '0)) | {rxGoodFrame, |irqSts_reg};
      end
   end
   assign irqOut = |(evtSts_reg & evtMask_reg);

   // ****************************************************
   // read data
   // ****************************************************
   // unmapped and write-only addresses read as zero
   // data stand for one cycle only; zero otherwise keeps the bus quiet
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         regRdData <= ZERO32;
      end else if (regRead) begin
         unique case (regAddr)
            OFS_FUNC_SEL: regRdData <= {5'h00, funcSel_reg}; // RL12
            OFS_PULL: regRdData <= {16'h0000, pull_reg};
            OFS_DIR: regRdData <= {23'h000000, dir_reg};
            OFS_OUT: regRdData <= {23'h000000, out_reg};
            OFS_IRQ_EN: regRdData <= {23'h000000, irqEn_reg};
            OFS_IRQ_STS: regRdData <= {23'h000000, irqSts_reg};
            OFS_IRQ_SENSE: regRdData <= {23'h000000, sense_reg};
            OFS_IRQ_MODE: regRdData <= {23'h000000, mode_reg};
            OFS_IRQ_BOTH: regRdData <= {23'h000000, both_reg};
            OFS_DEBOUNCE: regRdData <= {23'h000000, deb_reg};
            OFS_RAW: regRdData <= {23'h000000, syncLvl}; // RL9
            OFS_CLK_CTRL: regRdData <= {29'h00000000, clkCtrl_reg};
            OFS_BLINK: regRdData <= {24'h000000, blink_reg};
            OFS_EVT_STS: regRdData <= {30'h00000000, evtSts_reg};
            OFS_EVT_MASK: regRdData <= {30'h00000000, evtMask_reg};
            default: regRdData <= ZERO32;
         endcase
      end else begin
         regRdData <= ZERO32;
      end
   end

   // ****************************************************
   // pin output mux
   // ****************************************************
   // plain pins stay undriven until software turns the pin logic on
   // every pin output is registered, so a pin moves one cycle after its
   // cause and never glitches while a function field changes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pinOut <= '0;
         pinOe <= '0;
         syncIn <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pinOut[i] <= out_reg[i];
            pinOe[i] <= pinLogicOn & ~dir_reg[i]; // RL1
         end
         // pin 0 special functions
         unique case (funcSel_reg[FUNC_W-1:0])
            FN_SPECIAL: begin
               pinOut[0] <= ledActive; // RL4
               pinOe[0] <= 1'b1;
            end
            FN_ANT_SW: begin
               pinOut[0] <= txActive; // RL5
               pinOe[0] <= 1'b1;
            end
            // reserved codes fall back to plain use
            default: ;
         endcase
         // pin 7: sync test input with code 000, plain pin with 001, undriven otherwise
         // the test input is passed on only while the field keeps its reset code
         if (funcSel_reg[PIN_SYNC*FUNC_W +: FUNC_W] != FN_SPECIAL) begin
            pinOe[PIN_SYNC] <= 1'b0; // RL11
         end
         syncIn <= (funcSel_reg[PIN_SYNC*FUNC_W +: FUNC_W] == FN_PLAIN)
            & syncLvl[PIN_SYNC];
         // pin 8: interrupt request unless set to plain pin
         // it drives even with the pin logic off, so the host sees
         // requests straight after reset
         if (funcSel_reg[PIN_IRQ*FUNC_W +: FUNC_W] == FN_PLAIN) begin
            pinOut[PIN_IRQ] <= devIrq; // RL10
            pinOe[PIN_IRQ] <= 1'b1;
         end
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   // a good frame while pin 0 shows the indicator
   sequence frameSeen_s;
      rxGoodFrame && funcSel_reg[2:0] == FN_SPECIAL && blink_reg != '0;
   endsequence
   // visible two edges later: one for the timer, one for the pin register
   sequence ledHigh_s;
      ##2 pinOut[0] && pinOe[0];
   endsequence

   ledPulse_start_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
      frameSeen_s |-> ledHigh_s) else $error("indicator did not pulse");
   antSwitch_follow_a: assert property (@(posedge clk_sys) disable iff (reset) // RL5
      funcSel_reg[2:0] == FN_ANT_SW |=> pinOut[0] == $past(txActive))
      else $error("antenna switch not following tx");
   funcReserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // RL12
      $past(regRead) && $past(regAddr) == OFS_FUNC_SEL |-> regRdData[31:27] == 5'h00)
      else $error("reserved function bits not zero");
   // the edge that leaves reset still loads reset values, so it is skipped
   irqPin_default_a: assert property (@(posedge clk_sys) disable iff (reset) // RL10
      !reset && funcSel_reg[PIN_IRQ*FUNC_W +: FUNC_W] == FN_PLAIN
      |=> pinOe[PIN_IRQ] && pinOut[PIN_IRQ] == $past(devIrq))
      else $error("irq pin not driven");
   syncPin_input_a: assert property (@(posedge clk_sys) disable iff (reset) // RL11
      funcSel_reg[23:21] != FN_SPECIAL |=> !pinOe[PIN_SYNC])
      else $error("sync pin driven");
   pinSts_latch_a: assert property (@(posedge clk_sys) disable iff (reset) // RL9
      pinLogicOn && (pinHit & irqEn_reg) != '0 |=> (irqSts_reg & $past(pinHit & irqEn_reg))
      == $past(pinHit & irqEn_reg)) else $error("pin status not latched");
   pinLogic_off_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      !pinLogicOn ##1 !pinLogicOn |-> pinOe[3:1] == 3'h0)
      else $error("pin driven with logic off");
   funcWrite_take_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
      regWrite && regAddr == OFS_FUNC_SEL |=> funcSel_reg == $past(regWrData[26:0]))
      else $error("function select not stored");
   // a frame sets its event bit even if software clears it in that cycle
   goodFrame_event_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
      rxGoodFrame |=> evtSts_reg[EVT_W-1]) else $error("good frame event not set");
endmodule

// >>> core/pfs_pin_sync.sv
`timescale 1ns/1ns
module pfs_pin_sync
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pin
   input wire logic pinIn,
   // result
   output logic pinLevel
);
   // three-stage chain; stage one feeds stage two only
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // ****************************************************
   // synchroniser
   // ****************************************************
   // a change counts only when stages two and three agree
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         pinLevel <= 1'b0;
      end else begin
         s1_reg <= pinIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            pinLevel <= s3_reg;
         end
      end
   end
endmodule

// >>> core/pfs_pulse_timer.sv
`timescale 1ns/1ns
module pfs_pulse_timer
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // control
   input wire logic tick, // one step of the blink unit
   input wire logic trigger, // starts or restarts the pulse
   input wire logic [BLINK_W-1:0] length, // pulse length in steps
   // result
   output logic active
);
   // steps left in the current pulse
   logic [BLINK_W-1:0] left_reg;

   // ****************************************************
   // countdown
   // ****************************************************
   // a new trigger restarts the pulse so close frames merge into one
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         left_reg <= '0;
      end else if (trigger) begin
         left_reg <= (length == '0) ? BLINK_W'(1) : length;
      end else if (tick && left_reg != '0) begin
         left_reg <= left_reg - BLINK_W'(1);
      end
   end

   // output is registered via left_reg
   assign active = (left_reg != '0);
endmodule

// >>> inc/pfs_pkg.sv
package pfs_pkg;
   // ****************************************************
   // register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] OFS_FUNC_SEL = 8'h00; // pin_function_select
   localparam logic [7:0] OFS_PULL = 8'h04; // pin_drive_pull_control
   localparam logic [7:0] OFS_DIR = 8'h08; // pin_direction
   localparam logic [7:0] OFS_OUT = 8'h0C; // pin_output_value
   localparam logic [7:0] OFS_IRQ_EN = 8'h10; // pin_irq_enable
   localparam logic [7:0] OFS_IRQ_STS = 8'h14; // pin_irq_status
   localparam logic [7:0] OFS_IRQ_SENSE = 8'h18; // pin_irq_sense
   localparam logic [7:0] OFS_IRQ_MODE = 8'h1C; // pin_irq_level_edge
   localparam logic [7:0] OFS_IRQ_BOTH = 8'h20; // pin_irq_both_edges
   localparam logic [7:0] OFS_IRQ_CLR = 8'h24; // pin_irq_latch_clear
   localparam logic [7:0] OFS_DEBOUNCE = 8'h28; // pin_irq_debounce
   localparam logic [7:0] OFS_RAW = 8'h2C; // pin_raw_state
   localparam logic [7:0] OFS_CLK_CTRL = 8'h30; // pin-logic clock/reset control
   localparam logic [7:0] OFS_BLINK = 8'h34; // indicator blink time
   localparam logic [7:0] OFS_EVT_STS = 8'h38; // event status, write one to clear
   localparam logic [7:0] OFS_EVT_MASK = 8'h3C; // event mask

   // ****************************************************
   // field layout
   // ****************************************************
   localparam int NUM_PINS = 9;
   localparam int FUNC_W = 3;
   localparam int FUNC_BITS = 27; // bits 31..27 reserved
   localparam int PULL_W = 16;
   localparam int BLINK_W = 8;
   localparam int PIN_IRQ = 8; // pin carrying the interrupt request
   localparam int PIN_SYNC = 7; // pin with the reserved sync input
   localparam int CLK_EN_BIT = 0;
   localparam int DCLK_EN_BIT = 1;
   localparam int DRST_BIT = 2;
   localparam int EVT_W = 2; // 0: pin interrupt, 1: good frame seen

   // ****************************************************
   // function codes
   // ****************************************************
   localparam logic [2:0] FN_PLAIN = 3'h0;
   localparam logic [2:0] FN_SPECIAL = 3'h1;
   localparam logic [2:0] FN_ANT_SW = 3'h2;

   // ****************************************************
   // reset values and timing
   // ****************************************************
   localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
   localparam logic [BLINK_W-1:0] BLINK_RESET = 8'h10;
   localparam int CLK_MHZ = 50;
   localparam int BLINK_UNIT_US = 14; // one blink step lasts 14 us
   localparam int BLINK_UNIT_CYC = BLINK_UNIT_US * CLK_MHZ;
   localparam int DEB_UNIT_US = 1; // debounce sample period
   localparam int DEB_UNIT_CYC = DEB_UNIT_US * CLK_MHZ;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// >>> verification/pfs_pad_model.sv
`timescale 1ns/1ns
// ****************************************************
// pad model: pins, pull-ups and the indicator led
// ****************************************************
module pfs_pad_model
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // device side of the pads
   input wire logic [NUM_PINS-1:0] pinOut,
   input wire logic [NUM_PINS-1:0] pinOe,
   output logic [NUM_PINS-1:0] pinIn,
   // outside drivers, owned by the bench
   input wire logic [NUM_PINS-1:0] extDrive,
   input wire logic [NUM_PINS-1:0] extEn,
   // width of the last led pulse on pin 0, in cycles
   output logic [15:0] pulseLen
);
   logic [15:0] runLen; // cycles of the pulse in progress

   // wire level: the device wins, then the outside driver, else the pull-up
   // pull-ups are on after reset, so a released pin never floats
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pinOe[i]) begin
            pinIn[i] = pinOut[i];
         end else if (extEn[i]) begin
            pinIn[i] = extDrive[i];
         end else begin
            pinIn[i] = 1'b1;
         end
      end
   end

   // led timer: counts how long pin 0 stays lit
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         runLen <= 16'h0000;
         pulseLen <= 16'h0000;
      end else if (pinOe[0] && pinOut[0]) begin
         runLen <= runLen + 16'h0001;
      end else if (runLen != 16'h0000) begin
         pulseLen <= runLen;
         runLen <= 16'h0000;
      end
   end
endmodule

// >>> verification/pfs_pin_function_bank_tb.sv
`timescale 1ns/1ns
module pfs_pin_function_bank_tb
   import pfs_pkg::*;
;
   // ****************************************************
   // signals
   // ****************************************************
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdData;
   logic txActive = 1'b0;
   logic rxGoodFrame = 1'b0;
   logic devIrq = 1'b0;
   logic [NUM_PINS-1:0] pinIn, pinOut, pinOe;
   logic [NUM_PINS-1:0] extDrive = 9'h000;
   logic [NUM_PINS-1:0] extEn = 9'h000;
   logic syncIn, irqOut;
   logic [15:0] pulseLen;
   int failures = 0;
   int comparisons = 0;
   int n;

   always #10 clk_sys = ~clk_sys; // 50 MHz

   pfs_pin_function_bank dut (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .txActive(txActive), .rxGoodFrame(rxGoodFrame),
      .devIrq(devIrq), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .syncIn(syncIn), .irqOut(irqOut));

   pfs_pad_model pads (.clk_sys(clk_sys), .reset(reset), .pinOut(pinOut), .pinOe(pinOe),
      .pinIn(pinIn), .extDrive(extDrive), .extEn(extEn), .pulseLen(pulseLen));

   // ****************************************************
   // tasks
   // ****************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      check(regRdData & mask, exp);
   endtask

   // let c edges pass, then look once everything has settled
   task automatic settle(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask

   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      // reset values and an unmapped read
      rd(OFS_FUNC_SEL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(OFS_BLINK, 32'h0000_00FF, 32'h0000_0010);
      rd(OFS_DIR, 32'h0000_01FF, 32'h0000_01FF);
      rd(OFS_PULL, 32'h0000_FFFF, 32'h0000_FFFF);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
      // pin logic is off until clocks and reset release are set; pin 8 still
      // drives its interrupt request from reset
      check({23'h0, pinOe}, 32'h0000_0100);
      wr(OFS_CLK_CTRL, 32'h0000_0007);
      // pin 8 forwards the device interrupt after reset
      devIrq <= 1'b1;
      settle(4);
      check({30'h0, pinOe[8], pinOut[8]}, 32'h0000_0003);
      devIrq <= 1'b0;
      settle(4);
      check({31'h0, pinOut[8]}, 32'h0000_0000);
      // pin 7 in its reset function feeds the sync input, pulled high first
      check({31'h0, syncIn}, 32'h0000_0001);
      extEn[7] <= 1'b1;
      extDrive[7] <= 1'b0;
      settle(8);
      check({30'h0, pinOe[7], syncIn}, 32'h0000_0000);
      // reserved top bits read back as zero; only legal codes written
      wr(OFS_FUNC_SEL, 32'hF920_0000);
      rd(OFS_FUNC_SEL, 32'hFFFF_FFFF, 32'h0120_0000);
      // pin 0 as a plain output, then as antenna switch
      wr(OFS_DIR, 32'h0000_01FE);
      wr(OFS_OUT, 32'h0000_0001);
      settle(3);
      check({30'h0, pinOe[0], pinOut[0]}, 32'h0000_0003);
      wr(OFS_FUNC_SEL, 32'h0120_0002);
      settle(3);
      check({30'h0, pinOe[0], pinOut[0]}, 32'h0000_0002);
      txActive <= 1'b1;
      settle(3);
      check({30'h0, pinOe[0], pinOut[0]}, 32'h0000_0003);
      txActive <= 1'b0;
      settle(3);
      check({31'h0, pinOut[0]}, 32'h0000_0000);
      // good-frame indicator with a two-step blink
      wr(OFS_BLINK, 32'h0000_0002);
      wr(OFS_FUNC_SEL, 32'h0120_0001);
      settle(3);
      check({31'h0, pinOut[0]}, 32'h0000_0000);
      rxGoodFrame <= 1'b1;
      @(posedge clk_sys);
      rxGoodFrame <= 1'b0;
      settle(2);
      check({30'h0, pinOe[0], pinOut[0]}, 32'h0000_0003);
      n = 0;
      while (pinOut[0] === 1'b1 && n < 3000) begin
         settle(1);
         n++;
      end
      if (n >= 3000) begin
         failures++;
         end_of_test();
      end
      settle(2);
      // the step boundary may shorten the first step
      check({31'h0, pulseLen > BLINK_UNIT_CYC && pulseLen <= 2 * BLINK_UNIT_CYC + 4},
         32'h0000_0001);
      // sticky event, masked then unmasked, then cleared
      rd(OFS_EVT_STS, 32'h0000_0002, 32'h0000_0002);
      check({31'h0, irqOut}, 32'h0000_0000);
      wr(OFS_EVT_MASK, 32'h0000_0002);
      settle(1);
      check({31'h0, irqOut}, 32'h0000_0001);
      wr(OFS_EVT_STS, 32'h0000_0002);
      settle(1);
      check({31'h0, irqOut}, 32'h0000_0000);
      rd(OFS_EVT_STS, 32'h0000_0002, 32'h0000_0000);
      // pin 1 interrupt: rising level latches, clear removes it
      extEn[1] <= 1'b1;
      extDrive[1] <= 1'b0;
      wr(OFS_IRQ_SENSE, 32'h0000_0002);
      wr(OFS_IRQ_EN, 32'h0000_0002);
      settle(8);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0000);
      extDrive[1] <= 1'b1;
      settle(10);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0002);
      rd(OFS_RAW, 32'h0000_0002, 32'h0000_0002);
      rd(OFS_EVT_STS, 32'h0000_0001, 32'h0000_0001);
      extDrive[1] <= 1'b0;
      settle(8);
      wr(OFS_IRQ_CLR, 32'h0000_0002);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0000);
      rd(OFS_RAW, 32'h0000_0002, 32'h0000_0000);
      // the pin event bit stays sticky and raises the output once unmasked
      wr(OFS_EVT_MASK, 32'h0000_0001);
      settle(1);
      check({31'h0, irqOut}, 32'h0000_0001);
      // edge mode latches a held level once; both-edge mode adds the fall
      wr(OFS_IRQ_MODE, 32'h0000_0002);
      extDrive[1] <= 1'b1;
      settle(10);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0002);
      wr(OFS_IRQ_CLR, 32'h0000_0002);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0000);
      wr(OFS_IRQ_BOTH, 32'h0000_0002);
      extDrive[1] <= 1'b0;
      settle(10);
      rd(OFS_IRQ_STS, 32'h0000_0002, 32'h0000_0002);
      end_of_test();
   end
endmodule
